// [spfs_pkg.sv]
// package for the soft pin frequency scaling register group
package spfs_pkg;
    // ==========================================================
    // register indices (printed offsets, not multiples of four)
    localparam logic [11:0] SPFS_IDX_FREQ_SEL = 12'hc01;
    localparam logic [11:0] SPFS_IDX_SEC2_EN = 12'hc03;
    localparam logic [11:0] SPFS_IDX_REF_SCALE = 12'hc04;
    localparam logic [11:0] SPFS_IDX_OUT_SCALE = 12'hc05;
    localparam logic [11:0] SPFS_IDX_LOOP = 12'hc06;
    localparam logic [11:0] SPFS_IDX_START = 12'hc07;
    localparam logic [11:0] SPFS_IDX_SPRESET = 12'hc08;
    localparam logic [11:0] SPFS_IDX_STATUS = 12'hc10;
    localparam int SPFS_ADDR_W = 14;
    // ==========================================================
    // field positions and reset values
    localparam int SPFS_FLD_LO = 0;
    localparam int SPFS_FLD_HI = 2;
    localparam logic [7:0] SPFS_RST_BYTE = 8'h00;
    localparam logic [7:0] SPFS_MASK_EN = 8'h01;
    localparam logic [7:0] SPFS_MASK_SCALE = 8'h0f;
    localparam logic [7:0] SPFS_MASK_LOOP = 8'h1f;
    // ==========================================================
    // divide codes and timing
    localparam logic [1:0] SPFS_DIV1 = 2'b00;
    localparam logic [1:0] SPFS_DIV4 = 2'b01;
    localparam logic [1:0] SPFS_DIV8 = 2'b10;
    localparam logic [1:0] SPFS_DIV16 = 2'b11;
    localparam int SPFS_DL_NS = 200;
    localparam int SPFS_CLK_NS = 10;
    localparam int SPFS_DL_CYC = (SPFS_DL_NS + SPFS_CLK_NS - 1) / SPFS_CLK_NS;
    // applied configuration carried as one bundle
    typedef struct packed {
        logic [3:0] in_freq_sel;
        logic [4:0] ref0_div;
        logic [4:0] ref1_div;
        logic [4:0] ch0_div;
        logic [4:0] ch1_div;
        logic [4:0] loop_cfg;
    } spfs_cfg_t;
    typedef enum logic [1:0] {SPFS_IDLE, SPFS_LOAD, SPFS_DONE} spfs_state_t;
endpackage : spfs_pkg

// [spfs_code_div.sv]
// decodes a two-bit divide code into its divide ratio
`timescale 1ns/10ps
module spfs_code_div (
    input wire logic [1:0] code,
    output logic [4:0] ratio
);
    import spfs_pkg::*;
    // 00/01/10/11 map to 1/4/8/16
    always_comb begin
        case (code)
            SPFS_DIV1: ratio = 5'd1;
            SPFS_DIV4: ratio = 5'd4;
            SPFS_DIV8: ratio = 5'd8;
            SPFS_DIV16: ratio = 5'd16;
            default: ratio = 5'd1;
        endcase
    end
endmodule : spfs_code_div

// [spfs_top.sv]
// soft pin section two frequency scaling registers with apb access
// Function
// - enable low: section two settings ignored
// - enable high, select pin low: apply
// - second reference code bits 3:2 divide
// - first reference code bits 1:0 divide
// - channel one code bits 3:2 divide
// - channel zero code bits 1:0 divide
// - four-bit field picks base input frequency
// - settings apply only after start/reset trigger
// - start bit self-clears after download
`timescale 1ns/10ps
module spfs_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [spfs_pkg::SPFS_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic hard_program_select_pin,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output spfs_pkg::spfs_cfg_t cfg_applied,
    output logic download_busy
);
    import spfs_pkg::*;

    logic [7:0] freq_sel_r;
    logic [7:0] sec2_en_r;
    logic [7:0] ref_scale_r;
    logic [7:0] out_scale_r;
    logic [7:0] loop_r;
    logic start_r;
    logic spreset_r;
    spfs_state_t state_r;
    logic [7:0] cnt_r;
    logic [4:0] ratio [4];
    logic [1:0] codes [4];
    logic sec2_on;
    logic wr;
    logic [11:0] idx;
    logic idx_ok;
    logic [7:0] rd_byte;

    // ==========================================================
    // apb decode; one wait state so read data comes from a flop
    assign idx = paddr[13:2];
    // a misaligned write is refused like an unmapped one, triggers included
    assign wr = psel && penable && pready && pwrite && (paddr[1:0] == 2'b00);
    always_comb begin
        idx_ok = 1'b1;
        case (idx)
            SPFS_IDX_FREQ_SEL: rd_byte = freq_sel_r;
            SPFS_IDX_SEC2_EN: rd_byte = sec2_en_r;
            SPFS_IDX_REF_SCALE: rd_byte = ref_scale_r;
            SPFS_IDX_OUT_SCALE: rd_byte = out_scale_r;
            SPFS_IDX_LOOP: rd_byte = loop_r;
            SPFS_IDX_START: rd_byte = {7'h00, start_r};
            SPFS_IDX_SPRESET: rd_byte = {7'h00, spreset_r};
            SPFS_IDX_STATUS: rd_byte = {7'h00, download_busy};
            default: begin
                rd_byte = 8'h00;
                idx_ok = 1'b0;
            end
        endcase
    end

    // pready pulses in the access phase; data and error latch with it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
            if (psel && penable && !pready) begin
                prdata <= {24'h000000, rd_byte};
                pslverr <= !idx_ok || (paddr[1:0] != 2'b00);
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // ==========================================================
    // configuration registers; reserved bits are masked on write, except in freq_sel_r, which stores all eight bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            freq_sel_r <= SPFS_RST_BYTE;
            sec2_en_r <= SPFS_RST_BYTE;
            ref_scale_r <= SPFS_RST_BYTE;
            out_scale_r <= SPFS_RST_BYTE;
            loop_r <= SPFS_RST_BYTE;
        end else if (wr && paddr[1:0] == 2'b00) begin
            case (idx)
                SPFS_IDX_FREQ_SEL: freq_sel_r <= pwdata[7:0];
                SPFS_IDX_SEC2_EN: sec2_en_r <= pwdata[7:0] & SPFS_MASK_EN;
                SPFS_IDX_REF_SCALE: ref_scale_r <= pwdata[7:0] & SPFS_MASK_SCALE;
                SPFS_IDX_OUT_SCALE: out_scale_r <= pwdata[7:0] & SPFS_MASK_SCALE;
                SPFS_IDX_LOOP: loop_r <= pwdata[7:0] & SPFS_MASK_LOOP;
                default: ;
            endcase
        end
    end

    // ==========================================================
    // trigger bits: software sets, hardware clears at download end;
    // a set in the clearing cycle wins so no trigger is lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_r <= 1'b0;
            spreset_r <= 1'b0;
        end else begin
            if (wr && idx == SPFS_IDX_START && pwdata[0]) begin
                start_r <= 1'b1;
            end else if (state_r == SPFS_DONE) begin
                start_r <= 1'b0;
            end
            if (wr && idx == SPFS_IDX_SPRESET && pwdata[0]) begin
                spreset_r <= 1'b1;
            end else if (state_r == SPFS_DONE) begin
                spreset_r <= 1'b0;
            end
        end
    end

    // download sequencer models the ROM load time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= SPFS_IDLE;
            cnt_r <= 8'h00;
            download_busy <= 1'b0;
        end else begin
            case (state_r)
                SPFS_IDLE: begin
                    if (start_r || spreset_r) begin
                        state_r <= SPFS_LOAD;
                        cnt_r <= 8'(SPFS_DL_CYC - 1);
                        download_busy <= 1'b1;
                    end
                end
                SPFS_LOAD: begin
                    if (cnt_r == 8'h00) begin
                        state_r <= SPFS_DONE;
                    end else begin
                        cnt_r <= cnt_r - 8'h01;
                    end
                end
                SPFS_DONE: begin
                    state_r <= SPFS_IDLE;
                    download_busy <= 1'b0;
                end
                default: state_r <= SPFS_IDLE;
            endcase
        end
    end

    // ==========================================================
    // scale decoders, one per field
    assign sec2_on = sec2_en_r[0] && !hard_program_select_pin;
    assign codes[0] = ref_scale_r[SPFS_FLD_LO +: 2];
    assign codes[1] = ref_scale_r[SPFS_FLD_HI +: 2];
    assign codes[2] = out_scale_r[SPFS_FLD_LO +: 2];
    assign codes[3] = out_scale_r[SPFS_FLD_HI +: 2];
    for (genvar g = 0; g < 4; g++) begin : g_dec
        spfs_code_div u_dec (
            .code(sec2_on ? codes[g] : SPFS_DIV1),
            .ratio(ratio[g])
        );
    end

    // applied settings update only at the end of a download
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_applied <= '{4'h0, 5'd1, 5'd1, 5'd1, 5'd1, 5'd0};
        end else if (state_r == SPFS_DONE) begin
            cfg_applied.in_freq_sel <= freq_sel_r[3:0];
            cfg_applied.ref0_div <= ratio[0];
            cfg_applied.ref1_div <= ratio[1];
            cfg_applied.ch0_div <= ratio[2];
            cfg_applied.ch1_div <= ratio[3];
            cfg_applied.loop_cfg <= sec2_on ? loop_r[4:0] : 5'd0;
        end
    end

    // ==========================================================
    // checks
    property p_apply_at_done;
        @(posedge pclk) disable iff (!presetn)
        !(state_r == SPFS_DONE) |=> $stable(cfg_applied);
    endproperty
    a_apply_at_done: assert property (p_apply_at_done) else $error("config changed without download");

    property p_ignore_disabled;
        @(posedge pclk) disable iff (!presetn)
        (state_r == SPFS_DONE && !sec2_en_r[0]) |=>
            (cfg_applied.ref0_div == 5'd1 && cfg_applied.ref1_div == 5'd1 && cfg_applied.ch0_div == 5'd1 &&
            cfg_applied.ch1_div == 5'd1 && cfg_applied.loop_cfg == 5'd0);
    endproperty
    a_ignore_disabled: assert property (p_ignore_disabled) else $error("disabled section applied");

    property p_apply_enabled;
        @(posedge pclk) disable iff (!presetn)
        (state_r == SPFS_DONE && sec2_on && ref_scale_r[1:0] == 2'b11) |=> cfg_applied.ref0_div == 5'd16;
    endproperty
    a_apply_enabled: assert property (p_apply_enabled) else $error("first reference code not applied");

    property p_self_clear;
        @(posedge pclk) disable iff (!presetn)
        $rose(start_r) |-> ##[1:40] !start_r;
    endproperty
    a_self_clear: assert property (p_self_clear) else $error("start bit did not clear");

    property p_reserved_zero;
        @(posedge pclk) disable iff (!presetn)
        (ref_scale_r[7:4] == 4'h0) && (sec2_en_r[7:1] == 7'h00);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

    property p_out_reserved;
        @(posedge pclk) disable iff (!presetn)
        (out_scale_r[7:4] == 4'h0) && (loop_r[7:5] == 3'h0);
    endproperty
    a_out_reserved: assert property (p_out_reserved) else $error("reserved scale or loop bits set");
endmodule : spfs_top

// [spfs_tb.sv]
// self-checking apb testbench for the section two frequency scaling registers
`timescale 1ns/10ps
module testbench;
    import spfs_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [SPFS_ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic pin = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    spfs_cfg_t cfg_applied;
    logic download_busy;
    int bad_count = 0;
    int compares = 0;
    logic [31:0] q;
    logic e;
    spfs_cfg_t exp_cfg;
    // ==========================================================
    // clock, reset and design
    initial begin
        forever #5 pclk = ~pclk;
    end
    spfs_top u_spfs_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .hard_program_select_pin(pin), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cfg_applied(cfg_applied), .download_busy(download_busy));
    // ==========================================================
    // shared tasks
    task automatic conclude;
        $display("compares=%0d mismatches=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude
    task automatic chk(input string nm, input logic [31:0] xp, input logic [31:0] got);
        compares++;
        if (got !== xp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, xp, got);
        end
    endtask : chk
    // one apb transfer; the request is held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] idx, input logic [7:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            bad_count++;
            conclude();
        end
    endtask : apb
    // bounded wait for busy to rise and then fall again
    task automatic trig(input logic [11:0] idx);
        int n;
        apb(1'b1, idx, 8'h01);
        n = 0;
        while (download_busy !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        chk("busy rose", 32'h1, {31'h0, download_busy});
        while (download_busy !== 1'b0 && n < 80) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 80) begin
            bad_count++;
            conclude();
        end
        @(posedge pclk);
        apb(1'b0, idx, 8'h00);
        chk("trigger self clear", 32'h0, q);
    endtask : trig
    function automatic logic [4:0] rat(input int c);
        return (c == 0) ? 5'd1 : (c == 1) ? 5'd4 : (c == 2) ? 5'd8 : 5'd16;
    endfunction : rat
    // ==========================================================
    // scenarios
    task automatic t_reset;
        exp_cfg = '{4'h0, 5'd1, 5'd1, 5'd1, 5'd1, 5'd0};
        chk("reset cfg", 32'(exp_cfg), 32'(cfg_applied));
        chk("reset busy", 32'h0, {31'h0, download_busy});
        apb(1'b0, SPFS_IDX_SEC2_EN, 8'h00);
        chk("enable default", 32'h0, q);
        $display("test reset done");
    endtask : t_reset
    task automatic t_reserved;
        apb(1'b1, SPFS_IDX_REF_SCALE, 8'hff);
        apb(1'b0, SPFS_IDX_REF_SCALE, 8'h00);
        chk("ref scale reserved", 32'h0000000f, q);
        apb(1'b1, SPFS_IDX_SEC2_EN, 8'hfe);
        apb(1'b0, SPFS_IDX_SEC2_EN, 8'h00);
        chk("enable reserved", 32'h0, q);
        apb(1'b1, 12'hc02, 8'h55);
        chk("unmapped error", 32'h1, {31'h0, e});
        $display("test reserved done");
    endtask : t_reserved
    task automatic t_disabled;
        apb(1'b1, SPFS_IDX_OUT_SCALE, 8'hff);
        apb(1'b1, SPFS_IDX_FREQ_SEL, 8'h05);
        trig(SPFS_IDX_START);
        exp_cfg = '{4'h5, 5'd1, 5'd1, 5'd1, 5'd1, 5'd0};
        chk("disabled cfg", 32'(exp_cfg), 32'(cfg_applied));
        $display("test disabled done");
    endtask : t_disabled
    task automatic t_scale;
        apb(1'b1, SPFS_IDX_SEC2_EN, 8'h01);
        for (int c = 0; c < 4; c++) begin
            exp_cfg = cfg_applied;
            apb(1'b1, SPFS_IDX_REF_SCALE, 8'(c * 4 + (3 - c)));
            apb(1'b1, SPFS_IDX_OUT_SCALE, 8'((3 - c) * 4 + c));
            apb(1'b1, SPFS_IDX_FREQ_SEL, 8'(c + 12));
            apb(1'b1, SPFS_IDX_LOOP, 8'(c * 8 + 224));
            chk("cfg held", 32'(exp_cfg), 32'(cfg_applied));
            trig(c[0] ? SPFS_IDX_SPRESET : SPFS_IDX_START);
            exp_cfg = '{4'(c + 12), rat(3 - c), rat(c), rat(c), rat(3 - c), 5'(c * 8)};
            chk("scaled cfg", 32'(exp_cfg), 32'(cfg_applied));
        end
        $display("test scale done");
    endtask : t_scale
    task automatic t_pin;
        pin <= 1'b1;
        trig(SPFS_IDX_START);
        exp_cfg = '{4'hf, 5'd1, 5'd1, 5'd1, 5'd1, 5'd0};
        chk("pin high cfg", 32'(exp_cfg), 32'(cfg_applied));
        $display("test pin done");
    endtask : t_pin
    // ==========================================================
    // main sequence
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_reserved();
        t_disabled();
        t_scale();
        t_pin();
        conclude();
    end
endmodule : testbench
